// ===== hdl/vsm_engine.sv
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - sweep ignores line boundaries until region ends
// - region sweep bit high enables sweep
// - no sweep: train cut at line end
// - pulse from polarity, toggles, repeated count times
// - next region restarts normal sequence operation
// - multiplier toggle at value times length
// - multiplier keeps polarity and toggle usage
// - multiplier toggles step by pattern length
// - region multiplier bit high enables multiplier
// - one polarity, four 13-bit toggles per output
// - length field is the multiplication factor
// - multiplied toggles may cross line boundaries
// - any of 24 outputs may be gate
// - gate select register sits at 0x1c
// - gate uses polarity and two toggles
// - pattern select picks toggle pair per output
// - two active lines choose gate lines
// - gate active line references substrate clocking
// - per-field mask enables individual gate pulses
// - mask one suppresses, zero drives gate
// - mode: 0 off,1 sweep,2 mult,3 both
// - select zero first pair, one second
module vsm_engine #(
  parameter int NOUT = vsm_pkg::NUM_OUT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire vsm_pkg::vsm_frame_t frame,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [23:0] vertical_transfer_output,
  output logic [23:0] sensor_gate_pulse,
  output logic substrate_ref
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [23:0] sg_sel_r; // sensor_gate_output_select
  logic [23:0] pat_sel_r; // gate_pattern_select
  logic [23:0] mask_r; // gate_field_mask
  logic [12:0] line1_r; // gate_active_line_first
  logic [12:0] line2_r; // gate_active_line_second
  logic [17:0] mode_r; // region_mode_field, two bits per region
  logic [12:0] len_r; // pattern_length_factor
  logic [12:0] rep_cnt_r; // sequence_repeat_count (zero: no train)
  logic [23:0] pol_r; // pattern_start_polarity
  logic [12:0] tog_r [96]; // toggle table, out*4+tog
  logic [31:0] rdata_r; // read data, one cycle after strobe
  // engine state
  logic [3:0] idx_r; // current region
  logic [12:0] unit_r; // pixels inside one multiplier step
  logic [12:0] tc_r; // toggle compare counter
  logic [12:0] rep_r; // repetitions completed
  logic run_r; // train running
  logic [12:0] line_r; // line within field
  logic [23:0] xv_r; // vertical transfer outputs
  logic [23:0] sg_r; // sensor gate outputs
  logic sub_r; // substrate reference pulse
  // ****************************************************************
  // helpers
  // ****************************************************************
  // level after passing toggles a and b from a start polarity
  function automatic logic pair_lvl(input logic pol, input logic [12:0] tc,
    input logic [12:0] ta, input logic [12:0] tb);
    pair_lvl = pol ^ (tc >= ta) ^ (tc >= tb);
  endfunction

  // toggle table word index from byte address
  function automatic logic [6:0] tog_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - vsm_pkg::OFS_TOG;
    tog_idx = d[8:2];
  endfunction

  logic [1:0] mode; // mode of current region
  logic sweep; // sweep in current region
  logic mult; // multiplier in current region
  logic [12:0] last; // last count of one pulse or step
  logic restart; // region entry or line cut
  logic act_line; // gate active on this line
  logic [4:0] mpos; // bit position of region mode

  always_comb
  begin
    mpos = 5'({idx_r, 1'b0});
    mode = (idx_r < 4'(vsm_pkg::NUM_REG)) ? mode_r[mpos +: 2] : 2'h0;
    sweep = mode[vsm_pkg::MODE_SWEEP_BIT];
    mult = mode[vsm_pkg::MODE_MULT_BIT];
    // zero length behaves as one so the counter still moves
    last = (len_r == 13'h0000) ? 13'h0000 : len_r - 13'h0001;
    // sweep lets the train, multiplied or not, ride over line ends
    restart = frame.region_start | (frame.line_sync & ~sweep);
    act_line = (line_r == line1_r) || (line_r == line2_r);
  end

  // ****************************************************************
  // register write port
  // ****************************************************************
  // writes land immediately; changing a pattern mid-train glitches it
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sg_sel_r <= vsm_pkg::RST_SG_SEL;
      pat_sel_r <= 24'h000000;
      mask_r <= vsm_pkg::RST_MASK;
      line1_r <= vsm_pkg::RST_LINE;
      line2_r <= vsm_pkg::RST_LINE;
      mode_r <= 18'h00000;
      len_r <= vsm_pkg::RST_LEN;
      rep_cnt_r <= vsm_pkg::RST_REP;
      pol_r <= 24'h000000;
    end
    else if (reg_wr)
    begin
      if (reg_addr == vsm_pkg::OFS_SG_SEL)
        sg_sel_r <= reg_wdata[23:0];
      else if (reg_addr == vsm_pkg::OFS_PAT_SEL)
        pat_sel_r <= reg_wdata[23:0];
      else if (reg_addr == vsm_pkg::OFS_MASK)
        mask_r <= reg_wdata[23:0];
      else if (reg_addr == vsm_pkg::OFS_LINE1)
        line1_r <= reg_wdata[12:0];
      else if (reg_addr == vsm_pkg::OFS_LINE2)
        line2_r <= reg_wdata[12:0];
      else if (reg_addr == vsm_pkg::OFS_MODE)
        mode_r <= reg_wdata[17:0];
      else if (reg_addr == vsm_pkg::OFS_LEN)
        len_r <= reg_wdata[12:0];
      else if (reg_addr == vsm_pkg::OFS_REP)
        rep_cnt_r <= reg_wdata[12:0];
      else if (reg_addr == vsm_pkg::OFS_POL)
        pol_r <= reg_wdata[23:0];
    end
  end

  // toggle table, no reset: software loads it before use
  always_ff @(posedge mclk)
  begin
    if (reg_wr && reg_addr >= vsm_pkg::OFS_TOG && reg_addr < vsm_pkg::OFS_TOG_END)
      tog_r[tog_idx(reg_addr)] <= reg_wdata[12:0];
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  // data stands only in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !reg_rd)
      rdata_r <= 32'h00000000;
    else if (reg_addr == vsm_pkg::OFS_SG_SEL)
      rdata_r <= {8'h00, sg_sel_r};
    else if (reg_addr == vsm_pkg::OFS_PAT_SEL)
      rdata_r <= {8'h00, pat_sel_r};
    else if (reg_addr == vsm_pkg::OFS_MASK)
      rdata_r <= {8'h00, mask_r};
    else if (reg_addr == vsm_pkg::OFS_LINE1)
      rdata_r <= {19'h00000, line1_r};
    else if (reg_addr == vsm_pkg::OFS_LINE2)
      rdata_r <= {19'h00000, line2_r};
    else if (reg_addr == vsm_pkg::OFS_MODE)
      rdata_r <= {14'h0000, mode_r};
    else if (reg_addr == vsm_pkg::OFS_LEN)
      rdata_r <= {19'h00000, len_r};
    else if (reg_addr == vsm_pkg::OFS_REP)
      rdata_r <= {19'h00000, rep_cnt_r};
    else if (reg_addr == vsm_pkg::OFS_POL)
      rdata_r <= {8'h00, pol_r};
    else if (reg_addr == vsm_pkg::OFS_STAT)
      // running flag, region mode, region index, repetitions done
      rdata_r <= {run_r, 5'h00, mode, 4'h0, idx_r, 3'h0, rep_r};
    else if (reg_addr >= vsm_pkg::OFS_TOG && reg_addr < vsm_pkg::OFS_TOG_END)
      rdata_r <= {19'h00000, tog_r[tog_idx(reg_addr)]};
    else
      rdata_r <= 32'h00000000;
  end

  // ****************************************************************
  // region tracking
  // ****************************************************************
  // index latched on entry; a finished sweep hands over here
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      idx_r <= 4'h0;
    else if (frame.region_start)
      idx_r <= frame.region_idx;
  end

  // ****************************************************************
  // pulse train counters
  // ****************************************************************
  // normal: tc counts pixels, one pulse per length, repeated count times
  // multiplier: tc steps once per length pixels and ends at the count
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      unit_r <= 13'h0000;
      tc_r <= 13'h0000;
      rep_r <= 13'h0000;
      run_r <= 1'b0;
    end
    else if (restart)
    begin
      // region entry, or line cut when not sweeping
      unit_r <= 13'h0000;
      tc_r <= 13'h0000;
      rep_r <= 13'h0000;
      run_r <= (rep_cnt_r != 13'h0000);
    end
    else if (run_r && mult)
    begin
      if (unit_r == last)
      begin
        unit_r <= 13'h0000;
        // the count is the highest toggle, so the train ends there
        if (tc_r == rep_cnt_r)
          run_r <= 1'b0;
        else
          tc_r <= tc_r + 13'h0001;
      end
      else
        unit_r <= unit_r + 13'h0001;
    end
    else if (run_r)
    begin
      if (tc_r == last)
      begin
        // one pulse done, start the next repetition
        tc_r <= 13'h0000;
        rep_r <= rep_r + 13'h0001;
        if (rep_r + 13'h0001 == rep_cnt_r)
          run_r <= 1'b0;
      end
      else
        tc_r <= tc_r + 13'h0001;
    end
  end

  // ****************************************************************
  // field line counter and substrate reference
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      line_r <= 13'h0000;
    else if (frame.field_sync)
      line_r <= 13'h0000;
    else if (frame.line_sync)
      line_r <= line_r + 13'h0001;
  end

  // one-cycle mark as the first gate line begins
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      sub_r <= 1'b0;
    else if (frame.field_sync)
      sub_r <= (line1_r == 13'h0000);
    else
      sub_r <= frame.line_sync && (line_r + 13'h0001 == line1_r);
  end

  // ****************************************************************
  // output shaping
  // ****************************************************************
  // every output compared in parallel; idle outputs rest at polarity
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      xv_r <= 24'h000000;
      sg_r <= 24'h000000;
    end
    else
    begin
      for (int i = 0; i < NOUT; i++)
      begin
        if (!sg_sel_r[i])
        begin
          // transfer pulse: all four toggles, same in both modes
          xv_r[i] <= run_r ? pair_lvl(pair_lvl(pol_r[i], tc_r, tog_r[4*i], tog_r[4*i+1]),
            tc_r, tog_r[4*i+2], tog_r[4*i+3]) : pol_r[i];
          sg_r[i] <= 1'b0;
        end
        else
        begin
          xv_r[i] <= 1'b0;
          if (run_r && act_line && !mask_r[i])
            sg_r[i] <= pat_sel_r[i]
              ? pair_lvl(pol_r[i], tc_r, tog_r[4*i+2], tog_r[4*i+3])
              : pair_lvl(pol_r[i], tc_r, tog_r[4*i], tog_r[4*i+1]);
          else
            sg_r[i] <= pol_r[i];
        end
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign vertical_transfer_output = xv_r;
  assign sensor_gate_pulse = sg_r;
  assign substrate_ref = sub_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  // read data falls back to zero outside its one-cycle slot
  a_read_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(reg_rd) |-> rdata_r == 32'h00000000) else $error("read data outside slot");

  // a sweeping train keeps counting straight through a line boundary
  a_sweep_crosses_line: assert property (@(posedge mclk) disable iff (sys_rst)
    run_r && sweep && !mult && frame.line_sync && !frame.region_start && tc_r != last
    |=> tc_r == $past(tc_r) + 13'h0001) else $error("sweep train cut at line");

  // without sweep the line boundary clears both counters
  a_line_cut: assert property (@(posedge mclk) disable iff (sys_rst)
    frame.line_sync && !sweep |=> tc_r == 13'h0000 && unit_r == 13'h0000)
    else $error("train not cut at line end");

  // region entry starts over and latches the new index
  a_region_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    frame.region_start |=> tc_r == 13'h0000 && rep_r == 13'h0000 && idx_r == $past(frame.region_idx))
    else $error("region entry did not restart");

  // inside one multiplier step the compare counter stays put
  a_mult_step_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    run_r && mult && unit_r != last && !restart |=> tc_r == $past(tc_r))
    else $error("multiplier counter moved early");

  // last repetition stops the normal train
  a_repeat_done: assert property (@(posedge mclk) disable iff (sys_rst)
    run_r && !mult && !restart && tc_r == last && rep_r + 13'h0001 == rep_cnt_r |=> !run_r)
    else $error("train ran past repeat count");

  // masked gate outputs rest at their start polarity
  a_mask_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    1'b1 |=> (sg_r & $past(mask_r & sg_sel_r)) == $past(pol_r & mask_r & sg_sel_r))
    else $error("masked gate was driven");

  // stopped train leaves transfer outputs at polarity, gates of others low
  a_idle_polarity: assert property (@(posedge mclk) disable iff (sys_rst)
    !run_r |=> xv_r == $past(pol_r & ~sg_sel_r) && (sg_r & ~$past(sg_sel_r)) == 24'h000000)
    else $error("idle outputs off polarity");

  // the multiplier train ends once the step reaches the repeat count
  a_mult_train_end: assert property (@(posedge mclk) disable iff (sys_rst)
    run_r && mult && !restart && unit_r == last && tc_r == rep_cnt_r |=> !run_r)
    else $error("multiplier train ran past count");

  // a gate output never shows up on the transfer side
  a_gate_no_xfer: assert property (@(posedge mclk) disable iff (sys_rst)
    1'b1 |=> (xv_r & $past(sg_sel_r)) == 24'h000000)
    else $error("gate output drove transfer pin");

  // off the active lines every gate output rests at polarity
  a_gate_line_only: assert property (@(posedge mclk) disable iff (sys_rst)
    !act_line |=> ((sg_r ^ $past(pol_r)) & $past(sg_sel_r)) == 24'h000000)
    else $error("gate pulse off active line");

  // the boundary into the first active line marks substrate start
  a_sub_mark: assert property (@(posedge mclk) disable iff (sys_rst)
    frame.line_sync && !frame.field_sync && line_r + 13'h0001 == line1_r |=> sub_r)
    else $error("substrate mark missing");
endmodule

// ===== inc/vsm_pkg.sv
// ****************************************************************
// vertical sweep / multiplier / sensor gate constants
// ****************************************************************
package vsm_pkg;
  // geometry
  localparam int NUM_OUT = 24; // vertical outputs
  localparam int NUM_REG = 9; // regions per field
  localparam int NUM_TOG = 4; // toggles per output
  localparam int POS_W = 13; // toggle, length, repeat, line width
  localparam int ADDR_W = 12; // byte address width
  // register byte offsets
  localparam logic [11:0] OFS_SG_SEL = 12'h01c; // sensor_gate_output_select
  localparam logic [11:0] OFS_PAT_SEL = 12'h020; // gate_pattern_select
  localparam logic [11:0] OFS_MASK = 12'h024; // gate_field_mask
  localparam logic [11:0] OFS_LINE1 = 12'h028; // gate_active_line_first
  localparam logic [11:0] OFS_LINE2 = 12'h02c; // gate_active_line_second
  localparam logic [11:0] OFS_MODE = 12'h030; // region_mode_field, 2 bits/region
  localparam logic [11:0] OFS_LEN = 12'h034; // pattern_length_factor
  localparam logic [11:0] OFS_REP = 12'h038; // sequence_repeat_count
  localparam logic [11:0] OFS_POL = 12'h03c; // pattern_start_polarity
  localparam logic [11:0] OFS_STAT = 12'h040; // status, read only
  localparam logic [11:0] OFS_TOG = 12'h100; // toggle table, word k = out*4+tog
  localparam logic [11:0] OFS_TOG_END = 12'h280; // first byte past the table
  // field positions
  localparam int MODE_SWEEP_BIT = 0; // region mode bit: sweep
  localparam int MODE_MULT_BIT = 1; // region mode bit: multiplier
  localparam int STAT_RUN_BIT = 31; // status: train running
  localparam int STAT_MODE_LSB = 24; // status: current region mode
  localparam int STAT_IDX_LSB = 16; // status: current region index
  // reset values
  localparam logic [23:0] RST_SG_SEL = 24'h000000; // all vertical transfer
  localparam logic [23:0] RST_MASK = 24'hffffff; // every gate masked
  localparam logic [12:0] RST_LINE = 13'h1fff; // active line off the field
  localparam logic [12:0] RST_LEN = 13'h0001; // one pixel per pulse
  localparam logic [12:0] RST_REP = 13'h0000; // no train
  // framing from the field/region sequencer, all on mclk
  typedef struct packed {
    logic line_sync; // one-cycle pulse at each line boundary
    logic field_sync; // one-cycle pulse at field start
    logic region_start; // one-cycle pulse at each region change line
    logic [3:0] region_idx; // region entered on region_start
  } vsm_frame_t;
endpackage

// ===== sim/vsm_sensor_model.sv
`timescale 1ns/10ps
// ****************************************
// sensor side: counts shifts and gate pulses
// ****************************************
module vsm_sensor_model (
  input wire logic mclk,
  input wire logic clr,
  input wire logic [23:0] xfer,
  input wire logic [23:0] gate,
  input wire logic sub_ref,
  output logic [31:0] tally
);
  logic xp_r; // last level of transfer line 0
  logic gp_r; // last level of gate line 23
  logic [11:0] hi_r; // transfer high cycles
  logic [3:0] sh_r; // vertical shifts seen
  logic [3:0] su_r; // substrate references seen
  logic [3:0] ge_r; // charge transfers seen
  logic [7:0] gh_r; // gate high cycles
  // shift counting on line 0: a rise moves charge
  always_ff @(posedge mclk)
  begin
    xp_r <= xfer[0];
    if (clr)
    begin
      sh_r <= 4'h0;
      hi_r <= 12'h000;
    end
    else
    begin
      sh_r <= sh_r + 4'(xfer[0] & ~xp_r);
      hi_r <= hi_r + 12'(xfer[0]);
    end
  end
  // gate counting on line 23, the top driver slot
  always_ff @(posedge mclk)
  begin
    gp_r <= gate[23];
    if (clr)
    begin
      ge_r <= 4'h0;
      gh_r <= 8'h00;
      su_r <= 4'h0;
    end
    else
    begin
      ge_r <= ge_r + 4'(gate[23] & ~gp_r);
      gh_r <= gh_r + 8'(gate[23]);
      su_r <= su_r + 4'(sub_ref);
    end
  end
  assign tally = {gh_r, ge_r, su_r, sh_r, hi_r};
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [1:0] src; // 0 read data, 1 outputs, 2 tally
    logic [31:0] exp;
    logic [31:0] msk;
  } vsm_note_t;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  vsm_pkg::vsm_frame_t frame = '0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clr = 1'b0;
  logic rd_d = 1'b0; // read answer due this cycle
  logic probe_on = 1'b0; // output sample due this cycle
  logic [31:0] reg_rdata;
  logic [23:0] xfer;
  logic [23:0] gate;
  logic sub_ref;
  logic [31:0] tally;
  logic [31:0] obs;
  logic [31:0] r;
  vsm_note_t cur;
  vsm_note_t notes[$];
  int err_total = 0;
  int total_checks = 0;
  logic [12:0] tg0 [4] = '{13'h1, 13'h3, 13'h1fff, 13'h1fff};
  logic [12:0] tg23 [4] = '{13'h1, 13'h3, 13'h5, 13'h6};
  logic [31:0] gsel [3] = '{32'h0, 32'h800000, 32'h0};
  logic [31:0] gmsk [3] = '{32'h7fffff, 32'h7fffff, 32'hffffff};
  logic [31:0] gexp [3] = '{32'h04210000, 32'h02210000, 32'h00010000};
  always #2.5 mclk = ~mclk;
  vsm_engine u_dut (.mclk(mclk), .sys_rst(sys_rst), .frame(frame), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vertical_transfer_output(xfer), .sensor_gate_pulse(gate), .substrate_ref(sub_ref));
  vsm_sensor_model u_sensor (.mclk(mclk), .clr(clr), .xfer(xfer), .gate(gate),
    .sub_ref(sub_ref), .tally(tally));
  // ****************************************
  // drivers
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back('{2'd0, e, 32'hffffffff});
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic probe(input logic [1:0] s, input logic [31:0] e, input logic [31:0] m);
    @(posedge mclk);
    probe_on <= 1'b1;
    notes.push_back('{s, e, m});
    @(posedge mclk);
    probe_on <= 1'b0;
  endtask
  // kind 0 region change, 1 line boundary, 2 field start
  task automatic pulse(input int kind, input logic c, input logic [3:0] idx);
    @(posedge mclk);
    frame.region_start <= (kind == 0);
    frame.line_sync <= (kind == 1);
    frame.field_sync <= (kind == 2);
    frame.region_idx <= idx;
    clr <= c;
    @(posedge mclk);
    frame <= '0;
    clr <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // train from a region change, line boundary seen cut pixels later
  task automatic train(input logic [31:0] md, input logic [3:0] idx, input int cut,
    input logic [3:0] e_sh, input logic [11:0] e_hi);
    wr(vsm_pkg::OFS_MODE, md);
    pulse(0, 1'b1, idx);
    idle(cut - 2);
    pulse(1, 1'b0, idx);
    idle(80);
    probe(2'd2, {16'h0, e_sh, e_hi}, 32'h0000ffff);
  endtask
  // ****************************************
  // monitor: oldest note against what appears
  // ****************************************
  always @(posedge mclk) rd_d <= reg_rd;
  always @(negedge mclk)
  begin
    if (rd_d || probe_on)
    begin
      cur = notes.pop_front();
      obs = (cur.src == 2'd0) ? reg_rdata : (cur.src == 2'd1) ? {8'h0, xfer} : tally;
      total_checks++;
      if (((obs ^ cur.exp) & cur.msk) !== 32'h0)
      begin
        $display("wrong value at %0t: src %0d got %h want %h", $time, cur.src, obs, cur.exp);
        err_total++;
      end
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog well past the expected thousand or so cycles
  initial
  begin
    idle(20000);
    err_total++;
    give_verdict();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(25));
    idle(3);
    sys_rst <= 1'b0;
    probe(2'd1, 32'h0, 32'hffffffff);
    rd(vsm_pkg::OFS_SG_SEL, 32'h0);
    rd(vsm_pkg::OFS_MASK, 32'hffffff);
    rd(vsm_pkg::OFS_LINE1, 32'h1fff);
    rd(vsm_pkg::OFS_LEN, 32'h1);
    rd(vsm_pkg::OFS_MODE, 32'h0);
    wr(vsm_pkg::OFS_STAT, 32'hffffffff);
    rd(vsm_pkg::OFS_STAT, 32'h0);
    wr(12'h300, 32'hffffffff);
    rd(12'h300, 32'h0);
    wr(vsm_pkg::OFS_LINE2, 32'hffffffff);
    rd(vsm_pkg::OFS_LINE2, 32'h1fff);
    r = $urandom;
    wr(vsm_pkg::OFS_PAT_SEL, r);
    rd(vsm_pkg::OFS_PAT_SEL, {8'h0, r[23:0]});
    // unused outputs get random toggles, they only widen activity
    for (int o = 0; o < 24; o++)
      for (int t = 0; t < 4; t++)
        wr(vsm_pkg::OFS_TOG + 12'(16 * o + 4 * t),
          32'(o == 0 ? tg0[t] : o == 23 ? tg23[t] : 13'($urandom)));
    rd(vsm_pkg::OFS_TOG + 12'h4, 32'h3);
    wr(vsm_pkg::OFS_LEN, 32'h4);
    wr(vsm_pkg::OFS_REP, 32'h5);
    train(32'h0, 4'h0, 8, 4'h7, 12'd14);
    train(32'h1, 4'h0, 9, 4'h5, 12'd10);
    train(32'h1, 4'h1, 8, 4'h7, 12'd14);
    wr(vsm_pkg::OFS_TOG, 32'h2);
    wr(vsm_pkg::OFS_TOG + 12'h4, 32'h9);
    wr(vsm_pkg::OFS_REP, 32'h9);
    train(32'h2, 4'h0, 20, 4'h2, 12'd40);
    train(32'h3, 4'h0, 20, 4'h1, 12'd28);
    wr(vsm_pkg::OFS_MODE, 32'h0);
    wr(vsm_pkg::OFS_LEN, 32'h8);
    wr(vsm_pkg::OFS_REP, 32'h1);
    wr(vsm_pkg::OFS_SG_SEL, 32'hff8000);
    rd(vsm_pkg::OFS_SG_SEL, 32'hff8000);
    wr(vsm_pkg::OFS_LINE1, 32'h2);
    wr(vsm_pkg::OFS_LINE2, 32'h4);
    // gate lines 2 and 4 of six; pair select, then mask
    for (int k = 0; k < 3; k++)
    begin
      wr(vsm_pkg::OFS_PAT_SEL, gsel[k]);
      wr(vsm_pkg::OFS_MASK, gmsk[k]);
      pulse(2, 1'b1, 4'h0);
      repeat (5)
      begin
        pulse(1, 1'b0, 4'h0);
        idle(15);
      end
      probe(2'd2, gexp[k], 32'hffff0000);
      probe(2'd1, 32'h0, 32'hff8000);
    end
    give_verdict();
  end
endmodule
